// File: rdc_pkg.sv
// package for the reload down-counter pair: register map, fields, reset values
// assumes a classic wishbone slave with 32-bit data, one register per word
package rdc_pkg;
  // printed offsets are not word multiples, so they are indexes; byte address = index * 4
  localparam logic [8:0] IDX_CH0_CTRL = 9'h080; // channel control, coined name ch0_run_control
  localparam logic [8:0] IDX_CH0_PIN_IO = 9'h081; // ch0_pin_io_control
  localparam logic [8:0] IDX_CH0_MODE = 9'h082; // ch0_mode_config
  localparam logic [8:0] IDX_CH0_EVSEL = 9'h083; // ch0_event_source_select
  localparam logic [8:0] IDX_CH0_COUNT = 9'h084; // ch0_count_reload
  localparam logic [8:0] IDX_CH1_CTRL = 9'h088; // ch1_run_control
  localparam logic [8:0] IDX_CH1_PIN_IO = 9'h089; // ch1_pin_io_control
  localparam logic [8:0] IDX_CH1_MODE = 9'h08A; // ch1_mode_config
  localparam logic [8:0] IDX_CH1_EVSEL = 9'h08B; // ch1_event_source_select
  localparam logic [8:0] IDX_CH1_COUNT = 9'h08C; // ch1_count_reload
  localparam logic [8:0] IDX_PIN_ROUTE = 9'h180; // pin_route_select
  localparam int CH_STRIDE = 8; // index step between channels
  // control register fields
  localparam int CTL_RUN_REQUEST = 0; // run_request
  localparam int CTL_RUN_STATUS = 1; // run_status, read only
  localparam int CTL_FORCE_HALT = 2; // force_halt, reads 0
  localparam int CTL_EDGE_SEEN = 4; // edge_seen_flag
  localparam int CTL_UNDERFLOW = 5; // underflow_flag
  // mode register fields
  localparam int MODE_SEL_LSB = 0; // mode_select, 3 bits
  localparam int MODE_EDGE_COUNT = 3; // edge_count_select
  localparam int MODE_CLK_LSB = 4; // clock_source_select, 3 bits
  localparam int MODE_SRC_GATE = 7; // source_gate
  // event select fields
  localparam int EVSEL_CMP_LSB = 0; // compare_event_select, 2 bits
  localparam int EVSEL_INVERT = 2; // compare_event_invert
  // pin route fields
  localparam int ROUTE_CH0_LSB = 0; // ch0_pin_route
  localparam int ROUTE_CH1_LSB = 4; // ch1_pin_route
  localparam logic [1:0] ROUTE_PORT = 2'h1; // pin connected to its port pin
  // operating modes
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_PULSE_OUT = 3'h1;
  localparam logic [2:0] MODE_EVENT = 3'h2;
  localparam logic [2:0] MODE_WIDTH = 3'h3;
  localparam logic [2:0] MODE_PERIOD = 3'h4;
  // count clock sources
  localparam logic [2:0] CLK_UNDIV = 3'h0;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_OSC = 3'h2;
  localparam logic [2:0] CLK_DIV2 = 3'h3;
  localparam logic [2:0] CLK_LS_DIV32 = 3'h4;
  localparam logic [2:0] CLK_LS = 3'h6;
  localparam logic [2:0] CLK_CHAIN = 3'h7;
  // reset values
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [15:0] COUNT_HALT_VALUE = 16'hFFFF; // forced halt load
  localparam logic [15:0] COUNT_RESET = 16'hFFFF; // counter after reset
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
endpackage

// File: rdc_chan_if.sv
// interface between the register front end and one counting channel
// assumes both ends share clock and reset of the top module
`timescale 1ns/1ns
interface rdc_chan_if;
  logic [7:0] modeCfg; // mode register contents
  logic [7:0] evSel; // event select register contents
  logic runRequest; // counting requested
  logic countWrite; // pulse: load reload and counter
  logic [15:0] countData; // value for countWrite
  logic forceHalt; // pulse: force halt
  logic countTick; // qualified count clock pulse
  logic [15:0] counter; // current counter
  logic running; // counting in progress
  logic underflow; // pulse on underflow
  modport front (output modeCfg, evSel, runRequest, countWrite, countData, forceHalt, countTick,
                 input counter, running, underflow);
  modport chan (input modeCfg, evSel, runRequest, countWrite, countData, forceHalt, countTick,
                output counter, running, underflow);
endinterface

// File: rdc_channel.sv
// one 16-bit down-counting channel with its reload register
// assumes countTick is a one-cycle pulse already gated by source_gate
`timescale 1ns/1ns
module rdc_channel
  import rdc_pkg::*;
#(
  parameter int WIDTH = 16 // counter width
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic clkEn, // freezes state when low
  rdc_chan_if.chan ch // control and status
);
  logic [WIDTH-1:0] reloadValue; // reload register
  logic [WIDTH-1:0] counter; // live count
  logic running; // count status

  // reload register: loaded by software writes and forced halt
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reloadValue <= WIDTH'(COUNT_RESET);
    end else if (clkEn) begin
      if (ch.forceHalt) begin
        reloadValue <= WIDTH'(COUNT_HALT_VALUE);
      end else if (ch.countWrite) begin
        reloadValue <= WIDTH'(ch.countData);
      end
    end
  end

  // counter: decrement on tick, reload on underflow
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      counter <= WIDTH'(COUNT_RESET);
    end else if (clkEn) begin
      if (ch.forceHalt) begin
        counter <= WIDTH'(COUNT_HALT_VALUE);
      end else if (ch.countWrite) begin
        counter <= WIDTH'(ch.countData); // write lands whether running or not
      end else if (running && ch.countTick) begin
        if (counter == '0) begin
          counter <= reloadValue; // reload and keep going
        end else begin
          counter <= counter - WIDTH'(1);
        end
      end
    end
  end

  // run status follows run request; halt clears it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      running <= 1'b0;
    end else if (clkEn) begin
      if (ch.forceHalt) begin
        running <= 1'b0;
      end else begin
        running <= ch.runRequest;
      end
    end
  end

  assign ch.counter = 16'(counter);
  assign ch.running = running;
  // underflow only on a tick taken while the counter is zero; no tick means no underflow
  assign ch.underflow = clkEn && running && ch.countTick && (counter == '0) && !ch.forceHalt
                        && !ch.countWrite;
endmodule // rdc_channel

// File: reload_down_counter_pair.sv
// top of the two-channel reload down-counter with a classic wishbone slave
// assumes prescaled clock enables arrive as one-cycle pulses synchronous to clock
//
// Overview of operation
// - mode field selects timer, pulse, event, width, period
// - edge select: one or both edges, for event counting and the edge flag
// - clock field picks prescaled, oscillator, low-speed, chain
// - source gate 1 cuts count clock
// - compare select picks compare output D,C,B,A
// - invert bit picks low or high period
// - forced halt loads counter with FFFF
// - pin route 01 connects port pin
// - decrement each tick, reload on underflow
// - underflow rate is clock over value plus one
// - writing run request 1 starts counting
// - run request 0 or halt stops counting
// - every underflow raises interrupt request
// - count read returns live counter
// - count write updates reload and counter
// - halt clears run bits, reads zero
// - run status shows actual counting
// - flags cleared by writing 0 only
`timescale 1ns/1ns
module reload_down_counter_pair
  import rdc_pkg::*;
#(
  parameter int CHANNELS = 2 // number of channels
) (
  input wire logic clock, // 100 MHz system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic clkEn, // freezes state when low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic wb_err_o, // unmapped address
  input wire logic sysClkDivTwo, // divide-by-2 tick
  input wire logic sysClkDivEight, // divide-by-8 tick
  input wire logic onchipOscClk, // oscillator tick
  input wire logic lowSpeedClk, // low-speed tick
  input wire logic lowSpeedClkDiv32, // low-speed /32 tick
  input wire logic [3:0] compareOut, // compare outputs d,c,b,a in bits 0..3
  input wire logic [CHANNELS-1:0] ioPinIn, // channel pin input level
  output logic [CHANNELS-1:0] ioPinRouted, // pin connected to port pin
  output logic [CHANNELS-1:0] timerIrq, // underflow interrupt request pulse
  output logic [CHANNELS-1:0] eventGate // selected compare gate level
);
  logic [7:0] pinRoute; // pin_route_select
  logic [7:0] pinIo [CHANNELS]; // per-channel pin io control
  logic [7:0] modeCfg [CHANNELS]; // per-channel mode
  logic [7:0] evSel [CHANNELS]; // per-channel event select
  logic [CHANNELS-1:0] runRequest; // run_request bits
  logic [CHANNELS-1:0] underflowFlag; // underflow_flag bits
  logic [CHANNELS-1:0] edgeSeenFlag; // edge_seen_flag bits
  logic [CHANNELS-1:0] chanUnderflow; // underflow pulses
  logic [CHANNELS-1:0] chanRunning; // run status
  logic [15:0] chanCounter [CHANNELS]; // live counters
  logic [CHANNELS-1:0] ctrlWr; // control write strobe
  logic [CHANNELS-1:0] countWr; // count write strobe
  logic [CHANNELS-1:0] forceHaltWr; // halt pulse
  logic [CHANNELS-1:0] pinIoWr; // pin io write strobe
  logic [CHANNELS-1:0] modeWr; // mode write strobe
  logic [CHANNELS-1:0] evSelWr; // event select write strobe
  logic [CHANNELS-1:0] tickSel; // count ticks selected by mode, before source gate
  logic [CHANNELS-1:0] prevPin; // previous pin level
  logic [CHANNELS-1:0] edgeSeen; // pin edge detected
  logic busReq; // new request this cycle
  logic routeWr; // pin route write strobe
  logic [8:0] regIdx; // word index
  logic mapped; // address decodes
  logic [31:0] next_readData; // read mux

  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign regIdx = wb_adr_i[10:2];
  assign routeWr = busReq && wb_we_i && mapped && (regIdx == IDX_PIN_ROUTE) && wb_sel_i[0];

  // per-channel logic: strobes, clock select, channel instance
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    localparam logic [8:0] BASE = 9'(i * CH_STRIDE);
    rdc_chan_if cif();
    logic rawTick; // selected source before gate
    logic cmpLevel; // selected compare output

    // mapped keeps a refused access above the map from writing anything
    assign ctrlWr[i] = busReq && wb_we_i && mapped && (regIdx == IDX_CH0_CTRL + BASE) && wb_sel_i[0];
    assign pinIoWr[i] = busReq && wb_we_i && mapped && (regIdx == IDX_CH0_PIN_IO + BASE) && wb_sel_i[0];
    assign modeWr[i] = busReq && wb_we_i && mapped && (regIdx == IDX_CH0_MODE + BASE) && wb_sel_i[0];
    assign evSelWr[i] = busReq && wb_we_i && mapped && (regIdx == IDX_CH0_EVSEL + BASE) && wb_sel_i[0];
    // only a full 16-bit write loads the counter
    assign countWr[i] = busReq && wb_we_i && mapped && (regIdx == IDX_CH0_COUNT + BASE) && (wb_sel_i[1:0] == 2'h3);
    assign forceHaltWr[i] = ctrlWr[i] && wb_dat_i[CTL_FORCE_HALT];

    // count clock selection
    always_comb begin
      case (modeCfg[i][MODE_CLK_LSB +: 3])
        CLK_UNDIV: rawTick = 1'b1;
        CLK_DIV8: rawTick = sysClkDivEight;
        CLK_OSC: rawTick = onchipOscClk;
        CLK_DIV2: rawTick = sysClkDivTwo;
        CLK_LS_DIV32: rawTick = lowSpeedClkDiv32;
        CLK_LS: rawTick = lowSpeedClk;
        // chaining only from the lower channel; channel zero gets no clock
        CLK_CHAIN: rawTick = (i > 0) ? chanUnderflow[(i > 0) ? i - 1 : 0] : 1'b0;
        default: rawTick = 1'b0; // reserved code
      endcase
    end

    // compare event gate: select and polarity
    assign cmpLevel = compareOut[evSel[i][EVSEL_CMP_LSB +: 2]];
    assign eventGate[i] = evSel[i][EVSEL_INVERT] ? cmpLevel : !cmpLevel;

    // tick by mode; event mode counts pin edges gated by compare level
    always_comb begin
      case (modeCfg[i][MODE_SEL_LSB +: 3])
        MODE_TIMER, MODE_PULSE_OUT: tickSel[i] = rawTick;
        MODE_EVENT: tickSel[i] = edgeSeen[i] && eventGate[i];
        MODE_WIDTH, MODE_PERIOD: tickSel[i] = rawTick;
        default: tickSel[i] = 1'b0; // reserved modes do not count
      endcase
    end

    // pin edge detect: rising by default, falling by polarity, both by edge select
    assign edgeSeen[i] = modeCfg[i][MODE_EDGE_COUNT] ? (ioPinIn[i] ^ prevPin[i]) :
                         (pinIo[i][0] ? (prevPin[i] && !ioPinIn[i]) : (!prevPin[i] && ioPinIn[i]));

    assign cif.modeCfg = modeCfg[i];
    assign cif.evSel = evSel[i];
    assign cif.runRequest = runRequest[i];
    assign cif.countWrite = countWr[i];
    assign cif.countData = wb_dat_i[15:0];
    assign cif.forceHalt = forceHaltWr[i];
    assign cif.countTick = tickSel[i] && !modeCfg[i][MODE_SRC_GATE];
    assign chanUnderflow[i] = cif.underflow;
    assign chanRunning[i] = cif.running;
    assign chanCounter[i] = cif.counter;
    assign timerIrq[i] = cif.underflow;
    // route field 01 connects the pin; others leave it unused
    assign ioPinRouted[i] = pinRoute[(i == 0 ? ROUTE_CH0_LSB : ROUTE_CH1_LSB) +: 2] == ROUTE_PORT;

    rdc_channel #(.WIDTH(16)) u_chan (
      .clock(clock),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .ch(cif.chan)
    );
  end

  // previous pin level for edge detection
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prevPin <= '0;
    end else if (clkEn) begin
      prevPin <= ioPinIn;
    end
  end

  // configuration registers, byte lane 0
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinRoute <= REG8_RESET;
      for (int k = 0; k < CHANNELS; k++) begin
        pinIo[k] <= REG8_RESET;
        modeCfg[k] <= REG8_RESET;
        evSel[k] <= REG8_RESET;
      end
    end else if (clkEn) begin
      if (routeWr) begin
        pinRoute <= wb_dat_i[7:0] & 8'h33; // reserved bits read 0
      end
      for (int k = 0; k < CHANNELS; k++) begin
        if (pinIoWr[k]) begin
          pinIo[k] <= wb_dat_i[7:0] & 8'hF3;
        end
        if (modeWr[k]) begin
          modeCfg[k] <= wb_dat_i[7:0]; // written whether the channel runs or not
        end
        if (evSelWr[k]) begin
          evSel[k] <= wb_dat_i[7:0] & 8'h07;
        end
      end
    end
  end

  // run request bit: set by write 1, cleared by write 0 or halt
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      runRequest <= '0;
    end else if (clkEn) begin
      for (int k = 0; k < CHANNELS; k++) begin
        if (forceHaltWr[k]) begin
          runRequest[k] <= 1'b0;
        end else if (ctrlWr[k]) begin
          runRequest[k] <= wb_dat_i[CTL_RUN_REQUEST];
        end
      end
    end
  end

  // sticky flags: hardware set wins over a software clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      underflowFlag <= '0;
      edgeSeenFlag <= '0;
    end else if (clkEn) begin
      for (int k = 0; k < CHANNELS; k++) begin
        if (chanUnderflow[k]) begin
          underflowFlag[k] <= 1'b1;
        end else if (ctrlWr[k] && !wb_dat_i[CTL_UNDERFLOW]) begin
          underflowFlag[k] <= 1'b0;
        end
        if (edgeSeen[k] && chanRunning[k] && (modeCfg[k][2:0] == MODE_WIDTH || modeCfg[k][2:0] == MODE_PERIOD)) begin
          edgeSeenFlag[k] <= 1'b1;
        end else if (ctrlWr[k] && !wb_dat_i[CTL_EDGE_SEEN]) begin
          edgeSeenFlag[k] <= 1'b0;
        end
      end
    end
  end

  // address decode and read mux
  always_comb begin
    mapped = 1'b0;
    next_readData = '0;
    if (regIdx == IDX_PIN_ROUTE) begin
      mapped = 1'b1;
      next_readData = {24'h000000, pinRoute};
    end
    for (int k = 0; k < CHANNELS; k++) begin
      if (regIdx == IDX_CH0_CTRL + 9'(k * CH_STRIDE)) begin
        mapped = 1'b1;
        // halt bit always reads 0
        next_readData = {26'h0, underflowFlag[k], edgeSeenFlag[k], 2'h0, chanRunning[k], runRequest[k]};
      end
      if (regIdx == IDX_CH0_PIN_IO + 9'(k * CH_STRIDE)) begin
        mapped = 1'b1;
        next_readData = {24'h000000, pinIo[k]};
      end
      if (regIdx == IDX_CH0_MODE + 9'(k * CH_STRIDE)) begin
        mapped = 1'b1;
        next_readData = {24'h000000, modeCfg[k]};
      end
      if (regIdx == IDX_CH0_EVSEL + 9'(k * CH_STRIDE)) begin
        mapped = 1'b1;
        next_readData = {24'h000000, evSel[k]};
      end
      if (regIdx == IDX_CH0_COUNT + 9'(k * CH_STRIDE)) begin
        mapped = 1'b1;
        next_readData = {16'h0000, chanCounter[k]}; // live counter, not reload
      end
    end
    if (wb_adr_i[11]) begin
      mapped = 1'b0;
      next_readData = '0;
    end
  end

  // bus answer: one cycle after request, one-cycle ack or err
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clkEn) begin
      wb_ack_o <= busReq && mapped;
      wb_err_o <= busReq && !mapped;
      if (busReq && mapped && !wb_we_i) begin
        wb_dat_o <= next_readData;
      end
    end
  end
endmodule // reload_down_counter_pair

// File: rdc_pin_partner.sv
// pin partner: the external signal on one timer pin
// assumes routed tells whether the pin reaches its port pin
`timescale 1ns/1ns
module rdc_pin_partner #(
  parameter int HALF = 4 // cycles between level changes
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset
  input wire logic routed, // pin connected to port pin
  output logic level // level seen by the timer
);
  int cnt; // cycles since last change
  // slow square wave when routed, restless pattern otherwise
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      level <= 1'b0;
    end else if (!routed) begin // unrouted pin holds no steady value
      level <= ~level;
    end else if (cnt == HALF - 1) begin // edge every HALF cycles
      cnt <= 0;
      level <= ~level;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // rdc_pin_partner

// File: reload_down_counter_pair_assertions.sv
// checker for the reload down-counter pair, top ports only
// assumes one clock domain; bound to every instance of the top
`timescale 1ns/1ns
module reload_down_counter_pair_assertions
  import rdc_pkg::*;
#(
  parameter int CHANNELS = 2 // number of channels
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset
  input wire logic clkEn, // state enable
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic wb_err_o, // error
  input wire logic [3:0] compareOut, // compare levels
  input wire logic [CHANNELS-1:0] ioPinRouted, // routed pins
  input wire logic [CHANNELS-1:0] eventGate // gate levels
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [9:0] idx; // word index of the request
  logic taken; // request accepted at this edge
  logic isMapped; // index hits a register
  logic lastRd; // last accepted request was a read
  logic [9:0] lastIdx; // its index
  logic [7:0] route; // pin route shadow
  logic [7:0] ev0; // channel zero event select shadow
  logic [7:0] ev1; // channel one event select shadow
  assign idx = wb_adr_i[11:2];
  assign taken = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o & clkEn;
  assign isMapped = (idx == 10'(IDX_PIN_ROUTE)) || (idx >= 10'h080 && idx <= 10'h084)
                    || (idx >= 10'h088 && idx <= 10'h08C);
  // shadows of written registers and of the last request
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lastRd <= 1'b0;
      lastIdx <= 10'h000;
      route <= 8'h00;
      ev0 <= 8'h00;
      ev1 <= 8'h00;
    end else if (taken) begin // only accepted requests count
      lastRd <= ~wb_we_i;
      lastIdx <= idx;
      if (wb_we_i && wb_sel_i[0] && idx == 10'(IDX_PIN_ROUTE)) route <= wb_dat_i[7:0];
      if (wb_we_i && wb_sel_i[0] && idx == 10'(IDX_CH0_EVSEL)) ev0 <= wb_dat_i[7:0];
      if (wb_we_i && wb_sel_i[0] && idx == 10'(IDX_CH1_EVSEL)) ev1 <= wb_dat_i[7:0];
    end
  end
  a_req_answered: assert property (taken |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_err_unmapped: assert property (taken && !isMapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_ack_mapped: assert property (taken && isMapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access refused");
  a_route_pin: assert property (ioPinRouted == {route[5:4] == 2'h1, route[1:0] == 2'h1})
    else $error("pin routing differs from route field");
  a_gate_select: assert property (eventGate == {compareOut[ev1[1:0]] ~^ ev1[2],
                                                compareOut[ev0[1:0]] ~^ ev0[2]})
    else $error("event gate differs from selected compare level");
  a_halt_reads_zero: assert property (wb_ack_o && lastRd && (lastIdx == 10'(IDX_CH0_CTRL)
                                      || lastIdx == 10'(IDX_CH1_CTRL)) |-> wb_dat_o[7:0] == (wb_dat_o[7:0] & 8'h33))
    else $error("control read shows halt or unused bits");
  a_read_upper: assert property (wb_ack_o && lastRd |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
endmodule // reload_down_counter_pair_assertions

bind reload_down_counter_pair reload_down_counter_pair_assertions #(.CHANNELS(CHANNELS)) chk (
  .clock, .sys_rst, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .compareOut, .ioPinRouted, .eventGate);

// File: reload_down_counter_pair_tb_top.sv
// self-checking bench for the reload down-counter pair
// assumes the checker binds itself; ticks come from a free counter here
`timescale 1ns/1ns
module reload_down_counter_pair_tb_top
  import rdc_pkg::*;
;
  typedef struct packed { logic [8:0] idx; logic [15:0] val; } row_s;
  // route row first; channel zero pin io keeps polarity and filter at 0
  localparam row_s ROWS [14] = '{'{IDX_PIN_ROUTE, 16'h0011}, '{IDX_CH0_PIN_IO, 16'h0002},
    '{IDX_CH0_EVSEL, 16'h0007}, '{IDX_CH1_EVSEL, 16'h0004}, '{IDX_CH1_MODE, 16'h0001},
    '{IDX_CH1_MODE, 16'h000A}, '{IDX_CH1_MODE, 16'h0013}, '{IDX_CH1_MODE, 16'h0024},
    '{IDX_CH1_MODE, 16'h0040}, '{IDX_CH1_MODE, 16'h0060}, '{IDX_CH1_MODE, 16'h00F0},
    '{IDX_CH0_MODE, 16'h0080}, '{IDX_CH0_MODE, 16'h0000}, '{IDX_CH0_COUNT, 16'h1234}};
  localparam logic [8:0] RST_IDX [9] = '{IDX_CH0_CTRL, IDX_CH0_PIN_IO, IDX_CH0_MODE, IDX_CH0_EVSEL,
    IDX_CH1_CTRL, IDX_CH1_PIN_IO, IDX_CH1_MODE, IDX_CH1_EVSEL, IDX_PIN_ROUTE};
  localparam int PER [8] = '{1, 8, 3, 2, 7, 0, 5, 3}; // tick period per clock code; code 5 is reserved, code 7 follows channel zero underflows every 3 cycles
  logic clock = 1'b0; // system clock
  logic sys_rst = 1'b1; // reset
  logic wbCyc = 1'b0; // bus cycle
  logic wbStb = 1'b0; // bus strobe
  logic wbWe = 1'b0; // bus write
  logic [11:0] wbAdr = 12'h000; // bus address
  logic [3:0] wbSel = 4'h0; // lanes
  logic [31:0] wbDat = 32'h0; // write data
  logic [31:0] wbDatO; // read data
  logic ack; // acknowledge
  logic err; // error
  logic [4:0] tick = 5'h00; // div2, div8, osc, low, low/32
  logic [3:0] cmpOut = 4'h0; // compare levels
  logic [1:0] ioPinRouted; // routed pins
  logic [1:0] timerIrq; // interrupt pulses
  logic [1:0] pinLevel; // partner levels
  int tickCnt = 0; // free cycle count
  int mismatches = 0; // failed compares
  int checksDone = 0; // compares made
  always #5 clock = ~clock;
  // tick pulses of fixed periods, wandering compare levels
  always @(posedge clock) begin
    tickCnt <= tickCnt + 1;
    tick <= {tickCnt % 7 == 0, tickCnt % 5 == 0, tickCnt % 3 == 0, tickCnt % 8 == 0, tickCnt % 2 == 0};
    cmpOut <= tickCnt[7:4];
  end
  reload_down_counter_pair dut (.clock(clock), .sys_rst(sys_rst), .clkEn(1'b1), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(ack), .wb_err_o(err), .sysClkDivTwo(tick[0]),
    .sysClkDivEight(tick[1]), .onchipOscClk(tick[2]), .lowSpeedClk(tick[3]),
    .lowSpeedClkDiv32(tick[4]), .compareOut(cmpOut), .ioPinIn(pinLevel),
    .ioPinRouted(ioPinRouted), .timerIrq(timerIrq), .eventGate());
  rdc_pin_partner pin0 (.clock(clock), .sys_rst(sys_rst), .routed(ioPinRouted[0]), .level(pinLevel[0]));
  rdc_pin_partner pin1 (.clock(clock), .sys_rst(sys_rst), .routed(ioPinRouted[1]), .level(pinLevel[1]));
  // verdict and end of run
  task automatic endOfTest();
    if (mismatches == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, bounded wait for the answer
  task automatic bus(input logic w, input logic [8:0] i, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {1'b0, i, 2'b00};
    wbSel <= 4'hF; // whole word, so the count is one 16-bit access
    wbDat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    if (n >= 50) begin // no answer at all
      mismatches++;
      endOfTest();
    end
    r = wbDatO;
    e = err;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, i, d, r, e);
  endtask
  task automatic rd(input logic [8:0] i, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    bus(1'b0, i, 32'h0, r, e);
    check(r, exp);
  endtask
  // cycles between two interrupt pulses of one channel
  task automatic gap(input int ch, output int g);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (timerIrq[ch] !== 1'b1 && n < 400);
    g = 0;
    do begin
      @(negedge clock);
      g++;
    end while (timerIrq[ch] !== 1'b1 && g < 400);
  endtask
  // interrupt pulses seen over a number of cycles
  task automatic irqCount(input int ch, input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(negedge clock);
      if (timerIrq[ch] !== 1'b0) c++;
    end
  endtask
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    int g;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (RST_IDX[k]) rd(RST_IDX[k], 32'h0);
    rd(IDX_CH0_COUNT, 32'(COUNT_RESET));
    foreach (ROWS[k]) begin
      wr(ROWS[k].idx, 32'(ROWS[k].val));
      rd(ROWS[k].idx, 32'(ROWS[k].val));
    end
    wr(IDX_CH0_COUNT, 32'h2);
    wr(IDX_CH0_CTRL, 32'h1);
    gap(0, g);
    check(32'(g), 32'h3);
    for (int i = 0; i < 8; i++) begin
      if (i == 5) continue;
      wr(IDX_CH1_CTRL, 32'h0); // stopped before the mode write
      wr(IDX_CH1_MODE, 32'(i << 4));
      wr(IDX_CH1_COUNT, 32'h1); // nonzero load
      wr(IDX_CH1_CTRL, 32'h1);
      gap(1, g);
      check(32'(g), 32'(2 * PER[i]));
    end
    wr(IDX_CH0_CTRL, 32'h0);
    wr(IDX_CH0_MODE, 32'h70);
    wr(IDX_CH0_CTRL, 32'h1);
    irqCount(0, 50, g);
    check(32'(g), 32'h0);
    wr(IDX_CH0_CTRL, 32'h0);
    wr(IDX_CH0_MODE, 32'h80);
    wr(IDX_CH0_CTRL, 32'h1);
    wr(IDX_CH0_COUNT, 32'h1234);
    irqCount(0, 30, g);
    check(32'(g), 32'h0);
    rd(IDX_CH0_COUNT, 32'h1234);
    rd(IDX_CH0_CTRL, 32'h3);
    wr(IDX_CH0_CTRL, 32'h5);
    rd(IDX_CH0_COUNT, 32'hFFFF);
    rd(IDX_CH0_CTRL, 32'h0);
    wr(IDX_CH0_MODE, 32'h00);
    wr(IDX_CH0_COUNT, 32'h1);
    wr(IDX_CH0_CTRL, 32'h1);
    irqCount(0, 10, g);
    wr(IDX_CH0_CTRL, 32'h20);
    rd(IDX_CH0_CTRL, 32'h20);
    wr(IDX_CH0_CTRL, 32'h0);
    rd(IDX_CH0_CTRL, 32'h0);
    bus(1'b0, 9'h0FF, 32'h0, r, e);
    check(32'(e), 32'h1);
    endOfTest();
  end
endmodule // reload_down_counter_pair_tb_top
